// ### src/tone_wake_pkg.sv
package tone_wake_pkg;
    // ------------------------------------------------------------
    // Clock and derived timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS  = 8;          // 125 MHz reference clock
    localparam int TICK_PERIOD_NS = 40000;      // 25 kHz detector tick
    localparam int TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;
    localparam int BOOST_TIME_NS  = 10900000;   // 10.9 ms boost window
    localparam int BOOST_CYCLES   = BOOST_TIME_NS / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // Detector and charge pump constants
    // ------------------------------------------------------------
    localparam int         TONE_TICKS   = 128;         // Uninterrupted ticks before wake
    localparam logic [6:0] TONE_LAST    = 7'h7f;       // Last tick index of the tone count
    localparam logic [6:0] COUNT_RESET  = 7'h00;       // Count value after any restart
    localparam logic [5:0] SCALE_OFF    = 6'h00;       // Pump currents disabled
    localparam logic [5:0] SCALE_NORMAL = 6'h01;       // Nominal pump currents
    localparam logic [5:0] SCALE_BOOST  = 6'h2d;       // 45x pump currents
    localparam logic [3:0] DECAY_RATIO  = 4'ha;        // Decay to attack, 10:1

    // Detector states, one-hot
    typedef enum logic [2:0] {
        ST_SHUT = 3'b001,
        ST_HUNT = 3'b010,
        ST_WAKE = 3'b100
    } tone_state_t;
endpackage : tone_wake_pkg

// ### src/timing_if.sv
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------------------
// Timebase carrier between detector core and timer
// ------------------------------------------------------------
interface timing_if;
    logic tick;          // One-cycle 25 kHz tick
    logic clearTick;     // Restart the tick prescaler
    logic startBoost;    // One-cycle pulse on shutdown release
    logic boostActive;   // Boost window open

    modport core  (input tick, input boostActive, output clearTick, output startBoost);
    modport timer (output tick, output boostActive, input clearTick, input startBoost);
endinterface : timing_if
`default_nettype wire

// ### src/ref_timebase.sv
`timescale 1ns/10ps
`default_nettype none
module ref_timebase
    import tone_wake_pkg::*;
#(
    parameter int TICK_LEN  = TICK_CYCLES,
    parameter int BOOST_LEN = BOOST_CYCLES
) (
    input wire logic clk,
    input wire logic arst_n,
    timing_if.timer  tb
);
    // ------------------------------------------------------------
    // Local widths
    // ------------------------------------------------------------
    localparam int PW = $clog2(TICK_LEN);
    localparam int BW = $clog2(BOOST_LEN);

    logic [PW-1:0] prescale;        // Tick prescaler
    logic [PW-1:0] next_prescale;
    logic          tick;            // Registered tick pulse
    logic          next_tick;
    logic [BW-1:0] boostCount;      // Cycles spent in boost
    logic [BW-1:0] next_boostCount;
    logic          boostActive;     // Boost window flag
    logic          next_boostActive;

    assign tb.tick        = tick;
    assign tb.boostActive = boostActive;

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    // tick from reference
    always_comb begin
        next_prescale    = prescale + 1'b1;
        next_tick        = 1'b0;
        next_boostCount  = boostCount;
        next_boostActive = boostActive;
        // Clearing aligns tick phase to the tone start
        if (tb.clearTick) begin
            next_prescale = '0;
        end else if (prescale == PW'(TICK_LEN - 1)) begin
            next_prescale = '0;
            next_tick     = 1'b1;
        end
        if (tb.startBoost) begin
            next_boostCount  = '0;
            next_boostActive = 1'b1;
        end else if (boostActive) begin
            if (boostCount == BW'(BOOST_LEN - 1)) begin
                next_boostActive = 1'b0;
            end else begin
                next_boostCount = boostCount + 1'b1;
            end
        end
    end

    // Registers only
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            prescale    <= '0;
            tick        <= 1'b0;
            boostCount  <= '0;
            boostActive <= 1'b0;
        end else begin
            prescale    <= next_prescale;
            tick        <= next_tick;
            boostCount  <= next_boostCount;
            boostActive <= next_boostActive;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_boost_end: assert property (@(posedge clk) disable iff (!arst_n)
        (boostActive && boostCount == BW'(BOOST_LEN - 1) && !tb.startBoost) |=> !boostActive)
        else $error("boost window did not close at its last count");
    a_tick_spacing: assert property (@(posedge clk) disable iff (!arst_n)
        tick |-> prescale == '0 ##1 !tick)
        else $error("tick pulses too close together");
endmodule : ref_timebase
`default_nettype wire

// ### src/tone_wakeup_shutdown_control.sv
`timescale 1ns/10ps
`default_nettype none
// Operation
// - Wake output low on detected tone
// - Count uses 25 kHz tick from reference
// - Wake after 128 continuous ticks, else restart
// - Wake held low until tone ends
// - No wake while in shutdown
// - Shutdown high means standby, low runs
// - Shutdown disables both pump currents
// - After shutdown release pumps boosted 45x
// - Boost lasts fixed reference-derived time
// - Decay to attack ratio fixed 10:1
// - All timing from one reference clock
module tone_wakeup_shutdown_control
    import tone_wake_pkg::*;
#(
    parameter int TICK_LEN  = TICK_CYCLES,
    parameter int BOOST_LEN = BOOST_CYCLES
) (
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  wire logic       shutdown,
    input  wire logic       demodData,
    output var  logic       wakeRequestN,
    output var  logic       standby,
    output var  logic       pumpEnable,
    output var  logic       pumpBoost,
    output var  logic [5:0] pumpScale,
    output var  logic [3:0] decayToAttackRatio
);
    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    timing_if tb ();                   // Carrier to the timebase

    tone_state_t state;                // Detector state
    tone_state_t next_state;
    logic [6:0]  count;                // Ticks of unbroken tone
    logic [6:0]  next_count;
    logic        shutPrev;             // Shutdown one cycle ago
    logic        next_wakeRequestN;
    logic        next_standby;
    logic        next_pumpEnable;
    logic        next_pumpBoost;
    logic [5:0]  next_pumpScale;
    logic        clearTick;            // Restart tick phase
    logic        startBoost;           // Release edge of shutdown

    assign tb.clearTick  = clearTick;
    assign tb.startBoost = startBoost;

    // ------------------------------------------------------------
    // Timebase
    // ------------------------------------------------------------
    ref_timebase #(
        .TICK_LEN  (TICK_LEN),
        .BOOST_LEN (BOOST_LEN)
    ) u_timebase (
        .clk    (clk),
        .arst_n (arst_n),
        .tb     (tb.timer)
    );

    // ------------------------------------------------------------
    // Tone detector
    // ------------------------------------------------------------
    // tone is data high
    always_comb begin
        next_state = state;
        next_count = count;
        clearTick  = 1'b0;
        case (state)
            ST_SHUT: begin
                // Prescaler held clear, so the first tick lands a full period in
                next_count = COUNT_RESET;
                clearTick  = 1'b1;
                if (!shutdown) begin
                    next_state = ST_HUNT;
                end
            end
            ST_HUNT: begin
                if (shutdown) begin
                    next_state = ST_SHUT;
                    next_count = COUNT_RESET;
                end else if (!demodData) begin
                    next_count = COUNT_RESET;
                    clearTick  = 1'b1;
                end else if (tb.tick) begin
                    if (count == TONE_LAST) begin
                        next_state = ST_WAKE;
                        next_count = COUNT_RESET;
                    end else begin
                        next_count = count + 7'h01;
                    end
                end
            end
            ST_WAKE: begin
                if (shutdown) begin
                    // Count is already zero here, nothing more to clear
                    next_state = ST_SHUT;
                end else if (!demodData) begin
                    next_state = ST_HUNT;
                    clearTick  = 1'b1;
                end
            end
            default: begin
                next_state = ST_SHUT;
                next_count = COUNT_RESET;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Output and pump control
    // ------------------------------------------------------------
    always_comb begin
        next_wakeRequestN = (next_state != ST_WAKE);
        next_standby      = shutdown;
        next_pumpEnable   = !shutdown;
        next_pumpBoost    = !shutdown && tb.boostActive;
        // Off level tested first, so shutdown masks a running boost
        if (shutdown) begin
            next_pumpScale = SCALE_OFF;
        end else if (tb.boostActive) begin
            next_pumpScale = SCALE_BOOST;
        end else begin
            next_pumpScale = SCALE_NORMAL;
        end
        // Release edge; reset counts as a release too
        startBoost = shutPrev && !shutdown;
    end

    // Registers only; outputs reset to standby values
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state              <= ST_SHUT;
            count              <= COUNT_RESET;
            shutPrev           <= 1'b1;
            wakeRequestN       <= 1'b1;
            standby            <= 1'b1;
            pumpEnable         <= 1'b0;
            pumpBoost          <= 1'b0;
            pumpScale          <= SCALE_OFF;
            decayToAttackRatio <= DECAY_RATIO;
        end else begin
            state              <= next_state;
            count              <= next_count;
            shutPrev           <= shutdown;
            wakeRequestN       <= next_wakeRequestN;
            standby            <= next_standby;
            pumpEnable         <= next_pumpEnable;
            pumpBoost          <= next_pumpBoost;
            pumpScale          <= next_pumpScale;
            decayToAttackRatio <= DECAY_RATIO;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    a_shut_no_wake: assert property (shutdown |=> wakeRequestN)
        else $error("wake asserted during shutdown");
    a_wake_cause: assert property ($fell(wakeRequestN) |->
        $past(demodData) && $past(tb.tick) && $past(count) == TONE_LAST)
        else $error("wake fell without a full tone count");
    a_wake_release: assert property ((!wakeRequestN && !demodData) |=> wakeRequestN)
        else $error("wake not released when tone ended");
    a_wake_hold: assert property ((!wakeRequestN && demodData && !shutdown) |=> !wakeRequestN)
        else $error("wake dropped while tone continues");
    a_count_restart: assert property ((state == ST_HUNT && !demodData) |=> count == COUNT_RESET)
        else $error("count not cleared on tone break");
    a_pump_off: assert property (shutdown |=> !pumpEnable && pumpScale == SCALE_OFF)
        else $error("pump currents active in shutdown");
    a_boost_start: assert property (($past(shutdown) && !shutdown) ##1 !shutdown
        |=> pumpBoost && pumpScale == SCALE_BOOST)
        else $error("no boost after shutdown release");
    a_standby_level: assert property (standby == $past(shutdown) || $rose(arst_n))
        else $error("standby does not follow shutdown");
    a_ratio_fixed: assert property (decayToAttackRatio == DECAY_RATIO)
        else $error("decay to attack ratio changed");

    a_boost_scale: assert property (pumpBoost |-> pumpEnable && pumpScale == SCALE_BOOST)
        else $error("boost flag without boosted pump scale");
    a_boost_open: assert property (startBoost |=> tb.boostActive)
        else $error("boost window not opened on release");
    a_pump_standby: assert property (pumpEnable != standby)
        else $error("pump enable and standby disagree");
    a_wake_running: assert property (!wakeRequestN |-> !standby)
        else $error("wake low while in standby");
    a_count_idle: assert property ((state != ST_HUNT) |-> count == COUNT_RESET)
        else $error("tone count not idle outside hunt");
    a_break_no_tick: assert property ((state == ST_HUNT && !demodData) |=> !tb.tick)
        else $error("tick seen right after a tone break");

    // Main scenarios: wake, release, boost window, broken tone
    c_wake_fall:   cover property ($fell(wakeRequestN));
    c_boost_start: cover property ($rose(pumpBoost));
    c_wake_rise:   cover property ($rose(wakeRequestN) && !shutdown);
    c_boost_end:   cover property ($fell(pumpBoost) && !shutdown);
    c_tone_broken: cover property (state == ST_HUNT && count != COUNT_RESET && !demodData);
endmodule : tone_wakeup_shutdown_control
`default_nettype wire

// ### tb/decoder_model.sv
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------------------
// Far side: decoder that controls shutdown and feeds data
// ------------------------------------------------------------
module decoder_model (
    input  wire logic clk,
    input  wire logic wakeRequestN,
    output var  logic shutdown,
    output var  logic demodData
);
    int wakeEdges;    // Falling edges of wake seen by the decoder

    initial begin
        shutdown  = 1'b1;
        demodData = 1'b0;
        wakeEdges = 0;
    end

    // Count wakeups, as a sleeping decoder would
    always @(negedge wakeRequestN) begin
        wakeEdges = wakeEdges + 1;
    end

    // Change both lines just after a falling edge, away from sampling
    task automatic drive(input logic shut, input logic data);
        @(negedge clk);
        shutdown  = shut;
        demodData = data;
    endtask : drive

    // header: constant tone held for a number of clocks
    task automatic tone(input int n);
        drive(1'b0, 1'b1);
        repeat (n) @(negedge clk);
    endtask : tone
endmodule : decoder_model
`default_nettype wire

// ### tb/tone_wakeup_shutdown_control_tb.sv
`timescale 1ns/10ps
`default_nettype none
module tone_wakeup_shutdown_control_tb;
    import tone_wake_pkg::*;
    localparam int TL = 4;    // Short tick keeps the run brief
    localparam int BL = 20;   // Short boost window
    logic       clk;
    logic       arst_n;
    logic       shutdown;
    logic       demodData;
    logic       wakeRequestN;
    logic       standby;
    logic       pumpEnable;
    logic       pumpBoost;
    logic [5:0] pumpScale;
    logic [3:0] decayToAttackRatio;
    int         errors;
    int         checks_done;
    int         seed;
    int         n;
    int         i;

    // ------------------------------------------------------------
    // Design, far side and clock
    // ------------------------------------------------------------
    tone_wakeup_shutdown_control #(.TICK_LEN(TL), .BOOST_LEN(BL)) uut (
        .clk(clk), .arst_n(arst_n), .shutdown(shutdown), .demodData(demodData),
        .wakeRequestN(wakeRequestN), .standby(standby), .pumpEnable(pumpEnable),
        .pumpBoost(pumpBoost), .pumpScale(pumpScale), .decayToAttackRatio(decayToAttackRatio));
    decoder_model m (.clk(clk), .wakeRequestN(wakeRequestN), .shutdown(shutdown), .demodData(demodData));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Tone length that must pass before wake may fall
    function automatic int toneCycles(input int ticks);
        return ticks * TL;
    endfunction : toneCycles

    // Expected pump scale for a standby and boost state
    function automatic logic [5:0] expScale(input logic shut, input logic boost);
        return shut ? SCALE_OFF : (boost ? SCALE_BOOST : SCALE_NORMAL);
    endfunction : expScale

    // ------------------------------------------------------------
    // Compare, step and close
    // ------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Sample two ns after the rising edge, once updates have landed
    task automatic step(input int k);
        repeat (k) @(posedge clk);
        #2;
    endtask : step

    // Bounded wait for wake to fall; returns cycles waited
    task automatic waitWake(output int w);
        w = 0;
        while (wakeRequestN !== 1'b0 && w < 16) begin
            step(1);
            w++;
        end
    endtask : waitWake

    task automatic tally_and_finish;
        $display("errors %0d, checks %0d", errors, checks_done);
        if (errors == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : tally_and_finish

    // Cut a hang short well past the expected run
    initial begin
        // Span of forty full tone headers, far beyond the scenarios
        repeat (40 * toneCycles(TONE_TICKS)) @(posedge clk);
        errors++;
        tally_and_finish();
    end

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        errors = 0;
        checks_done = 0;
        seed = 32'h542f33ca;
        arst_n = 1'b0;
        step(4);
        check(wakeRequestN, 8'h01);                 // idle high in reset
        check(pumpScale, expScale(1'b1, 1'b0));     // currents off
        @(negedge clk);
        arst_n = 1'b1;
        step(3);
        check(standby, 8'h01);                      // high input means standby
        check(pumpEnable, 8'h00);                   // charge frozen
        // Release: count boosted cycles, then nominal
        m.drive(1'b0, 1'b0);
        n = 0;
        for (i = 0; i < BL + 12; i++) begin
            step(1);
            if (pumpBoost === 1'b1 && pumpScale === SCALE_BOOST) n++;
        end
        check(8'(n), 8'(BL));                       // boost length
        check(pumpScale, expScale(1'b0, 1'b0));     // back to nominal
        check(standby, 8'h00);                      // running
        check(decayToAttackRatio, DECAY_RATIO);     // fixed ratio
        // Full tone: wake falls near 128 ticks, not before
        m.drive(1'b0, 1'b1);
        step(toneCycles(TONE_TICKS) - 6);
        check(wakeRequestN, 8'h01);                 // not early
        waitWake(n);
        check(wakeRequestN, 8'h00);                 // wake on tone
        step(10);
        check(wakeRequestN, 8'h00);                 // held while tone
        m.drive(1'b0, 1'b0);
        step(2);
        check(wakeRequestN, 8'h01);                 // released on data
        // Tone broken one tick short of the count restarts it
        m.tone(toneCycles(TONE_TICKS - 1));
        m.drive(1'b0, 1'b0);
        m.tone(toneCycles(TONE_TICKS) - 8);
        check(wakeRequestN, 8'h01);                 // count restarted
        waitWake(n);
        check(wakeRequestN, 8'h00);                 // restarted count completes
        m.drive(1'b0, 1'b0);
        // Random toggling data never holds long enough
        n = m.wakeEdges;
        for (i = 0; i < 40; i++) begin
            m.tone(($random(seed) & 32'h7f) + 1);
            m.drive(1'b0, 1'b0);
        end
        check(8'(m.wakeEdges - n), 8'h00);          // low sample restarts
        // Shutdown in mid wake clears, and holds detector idle
        m.tone(toneCycles(TONE_TICKS) + 8);
        check(wakeRequestN, 8'h00);                 // woken before shutdown
        m.drive(1'b1, 1'b1);
        step(2);
        check(wakeRequestN, 8'h01);                 // cleared on shutdown
        check({pumpEnable, pumpBoost, standby}, 8'h01); // frozen and standby
        n = m.wakeEdges;
        step(toneCycles(TONE_TICKS) + 40);
        check(8'(m.wakeEdges - n), 8'h00);          // no wake in standby
        // Release with tone already up: full count again, boost again
        m.drive(1'b0, 1'b1);
        step(3);
        check(pumpScale, expScale(1'b0, 1'b1));     // boost on release
        step(toneCycles(TONE_TICKS) - 10);
        check(wakeRequestN, 8'h01);                 // count started afresh
        waitWake(n);
        check(wakeRequestN, 8'h00);                 // wake after full count
        m.drive(1'b0, 1'b0);
        step(4);
        // Mid-run reset with shutdown low: release acts as a boost start
        @(negedge clk);
        arst_n = 1'b0;
        step(2);
        check({standby, pumpEnable, pumpBoost}, 8'h04); // standby values in reset
        @(negedge clk);
        arst_n = 1'b1;
        step(1);
        check(pumpScale, expScale(1'b0, 1'b0));     // nominal before boost
        step(1);
        check(pumpScale, expScale(1'b0, 1'b1));     // boost after release
        check(wakeRequestN, 8'h01);                 // detector cleared
        step(4);
        tally_and_finish();
    end
endmodule : tone_wakeup_shutdown_control_tb
`default_nettype wire
